// >>> logic/stream_acq_defines.vh
// constants for the streaming acquisition controller
`ifndef STREAM_ACQ_DEFINES_VH
`define STREAM_ACQ_DEFINES_VH
// ==========================================
// register indices and byte addresses
`define IDX_OPERATING_MODE_SELECT 16'h251c
`define IDX_SEGMENT_LENGTH        16'h271a
`define IDX_SEGMENT_COUNT         16'h2724
`define IDX_PRE_TRIGGER_LENGTH    16'h272e
`define ADR_OPERATING_MODE_SELECT 16'h9470
`define ADR_SEGMENT_LENGTH_LO     16'h9c68
`define ADR_SEGMENT_LENGTH_HI     16'h9c6c
`define ADR_SEGMENT_COUNT_LO      16'h9c90
`define ADR_SEGMENT_COUNT_HI      16'h9c94
`define ADR_PRE_TRIGGER_LO        16'h9cb8
`define ADR_PRE_TRIGGER_HI        16'h9cbc
`define ADR_COMMAND               16'h0000
`define ADR_IRQ_STATUS            16'h0004
`define ADR_IRQ_MASK              16'h0008
`define ADR_HOST_FREED_BYTES      16'h000c
`define ADR_HOST_AVAILABLE_BYTES  16'h0010
`define ADR_HOST_BUFFER_BYTES     16'h0014
`define ADR_RATE_CONTROL          16'h0018
`define ADR_LIVE_STATE            16'h001c
// ==========================================
// mode codes
`define MODE_CONTINUOUS_STREAM    32'h00000010
`define MODE_MEMORY_SINGLE        32'h00000001
// ==========================================
// command bits
`define CMD_BEGIN_CAPTURE         0
`define CMD_ARM_TRIGGER           1
`define CMD_STOP                  2
// ==========================================
// status bits, mask has the same layout
`define ST_PARAM_ERROR            0
`define ST_DONE                   9
`define ST_OVERRUN                10
`define ST_USED_MASK              32'h00000601
// ==========================================
// step and minimum limits
`define STEP_NORMAL_LOG2          2
`define STEP_INTERLACE_LOG2       3
`define PRE_MIN_NORMAL            64'h0000000000000004
`define PRE_MIN_INTERLACE         64'h0000000000000008
`define SEG_MIN_NORMAL            64'h0000000000000008
`define SEG_MIN_INTERLACE         64'h0000000000000010
`define PRE_DEPTH_DEFAULT         16352
`define MEM_BYTES_DEFAULT         65536
`endif

// >>> logic/byte_fifo.v
// first-word-fall-through byte fifo held in a local array
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             mclk,
  input  wire             srst,
  // control
  input  wire             flush,
  input  wire             push,
  input  wire [WIDTH-1:0] wdata,
  input  wire             pop,
  // state
  output wire [WIDTH-1:0] rdata,
  output wire [AW:0]      count,
  output wire             full,
  output wire             empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            do_push;
  wire            do_pop;
  localparam integer  LAST_I = DEPTH - 1;
  localparam [AW-1:0] LAST   = LAST_I[AW-1:0];   // last slot index, cut to pointer width

  // ==========================================
  // qualified strobes and flags
  assign full    = (count_ff == DEPTH);
  assign empty   = (count_ff == {(AW+1){1'b0}});
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign rdata   = mem[rd_ptr_ff];
  assign count   = count_ff;

  // storage write
  always @(posedge mclk)
  begin
    if (do_push)
      mem[wr_ptr_ff] <= wdata;
  end

  // pointers and fill level
  always @(posedge mclk)
  begin
    if (srst | flush)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr_ff <= (wr_ptr_ff == LAST) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      if (do_pop)
        rd_ptr_ff <= (rd_ptr_ff == LAST) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      if (do_push & ~do_pop)
        count_ff <= count_ff + 1'b1;
      else if (do_pop & ~do_push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule

// >>> logic/fifo_stream_acquisition.v
// streaming acquisition control with ahb-lite register slave
`timescale 1ns/1ps
`include "stream_acq_defines.vh"

// Functional notes
// RULE1: mode code 10h selects continuous streaming to host memory.
// RULE2: reading the mode register returns the mode in effect.
// RULE3: whole on-board memory acts as fifo between converters and host.
// RULE4: pre-trigger register sets samples kept before trigger, delivered first.
// RULE5: segment length sets samples per channel in one segment.
// RULE6: segment count sets total segments; zero runs until stopped.
// RULE7: nonzero count ends after count times length samples.
// RULE8: stop command ends capture regardless of programmed length.
// RULE9: pre-trigger samples live in a small dedicated pre-trigger fifo.
// RULE10: each sample takes one byte of memory.
// RULE11: software programs values only in permitted step multiples.
// RULE12: above 100 MS/s two converters interleave on opposite clock phases.
// RULE13: interlace uses its own minimum and step limits.
// RULE14: host sets destination buffer and size before start.
// RULE15: host reports consumed bytes so freed space refills.
// RULE16: overrun flag rises when host drains too slowly.
// RULE17: pre-trigger area fills first; trigger armed only once full.
// RULE18: finite capture flags completion once all data reached the host.
module fifo_stream_acquisition #(
  parameter MEM_BYTES = `MEM_BYTES_DEFAULT,
  parameter MEM_AW    = 16,
  parameter PRE_DEPTH = `PRE_DEPTH_DEFAULT,
  parameter PRE_AW    = 14
) (
  // clock and reset
  input  wire        mclk,
  input  wire        srst,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // converters
  input  wire        sample_en,
  input  wire [7:0]  adc0_data,
  input  wire [7:0]  adc1_data,
  input  wire        trig_in,
  // stream to host transfer engine
  output reg  [7:0]  out_data,
  output reg         out_valid,
  input  wire        out_ready,
  // interrupt
  output wire        irq
);
  localparam [2:0] S_IDLE    = 3'd0;
  localparam [2:0] S_PREFILL = 3'd1;
  localparam [2:0] S_ARMED   = 3'd2;
  localparam [2:0] S_RUN     = 3'd3;
  localparam [2:0] S_FLUSH   = 3'd4;

  reg [2:0]   state_ff;
  reg [31:0]  mode_ff;
  reg [63:0]  seg_len_ff;
  reg [63:0]  seg_cnt_ff;
  reg [63:0]  pre_len_ff;
  reg [31:0]  status_ff;
  reg [31:0]  mask_ff;
  reg [31:0]  buf_bytes_ff;
  reg [31:0]  credit_ff;
  reg         interlace_ff;
  reg         arm_ff;
  reg         phase_ff;
  reg [63:0]  in_seg_ff;
  reg [63:0]  loops_done_ff;
  reg         wr_pend_ff;
  reg [15:0]  wr_addr_ff;
  reg [31:0]  nxt_rdata;
  wire [7:0]  sample;
  wire        capture;
  wire        take;
  wire [7:0]  pre_rdata;
  wire [PRE_AW:0] pre_count;
  wire        pre_full;
  wire        pre_empty;
  wire [7:0]  mem_rdata;
  wire [MEM_AW:0] mem_count;
  wire        mem_full;
  wire        mem_empty;
  wire [63:0] pre_cnt64;
  wire        pre_reached;
  wire        pre_push;
  wire        pre_pop;
  wire        mem_push;
  wire        mem_pop;
  wire        finished;
  wire        addr_ok;
  wire        rd_req;
  wire        wr_cmd;
  wire        begin_ok;
  wire        params_ok;
  wire [2:0]  step_mask;
  wire [63:0] pre_min;
  wire [63:0] seg_min;
  wire        last_sample;
  wire        ovr_evt;
  wire        done_evt;
  wire        perr_evt;
  wire        stat_rd;
  wire        freed_wr;

  // ==========================================
  // ahb-lite decode, zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];
  assign rd_req    = addr_ok & ~hwrite;
  assign stat_rd   = rd_req & (haddr[15:0] == `ADR_IRQ_STATUS);
  assign wr_cmd    = wr_pend_ff & (wr_addr_ff == `ADR_COMMAND);
  assign freed_wr  = wr_pend_ff & (wr_addr_ff == `ADR_HOST_FREED_BYTES);

  // write address phase capture
  always @(posedge mclk)
  begin
    if (srst)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 16'h0000;
    end
    else
    begin
      wr_pend_ff <= addr_ok & hwrite;
      wr_addr_ff <= haddr[15:0];
    end
  end

  // read mux, unmapped reads as zero
  always @*
  begin
    nxt_rdata = 32'h00000000;
    case (haddr[15:0])
      `ADR_OPERATING_MODE_SELECT: nxt_rdata = mode_ff;                       // [RULE2]
      `ADR_SEGMENT_LENGTH_LO:     nxt_rdata = seg_len_ff[31:0];
      `ADR_SEGMENT_LENGTH_HI:     nxt_rdata = seg_len_ff[63:32];
      `ADR_SEGMENT_COUNT_LO:      nxt_rdata = seg_cnt_ff[31:0];
      `ADR_SEGMENT_COUNT_HI:      nxt_rdata = seg_cnt_ff[63:32];
      `ADR_PRE_TRIGGER_LO:        nxt_rdata = pre_len_ff[31:0];
      `ADR_PRE_TRIGGER_HI:        nxt_rdata = pre_len_ff[63:32];
      `ADR_IRQ_STATUS:            nxt_rdata = status_ff;
      `ADR_IRQ_MASK:              nxt_rdata = mask_ff;
      `ADR_HOST_AVAILABLE_BYTES:  nxt_rdata = buf_bytes_ff - credit_ff;     // [RULE15]
      `ADR_HOST_BUFFER_BYTES:     nxt_rdata = buf_bytes_ff;
      `ADR_RATE_CONTROL:          nxt_rdata = {31'h00000000, interlace_ff};
      `ADR_LIVE_STATE:            nxt_rdata = {arm_ff, state_ff, {(28-MEM_AW-1){1'b0}}, mem_count};
      default:                    nxt_rdata = 32'h00000000;
    endcase
  end

  // read data loaded at the address phase edge
  always @(posedge mclk)
  begin
    if (srst)
      hrdata <= 32'h00000000;
    else if (rd_req)
      hrdata <= nxt_rdata;
  end

  // ==========================================
  // configuration registers
  always @(posedge mclk)
  begin
    if (srst)
    begin
      mode_ff      <= `MODE_MEMORY_SINGLE;
      seg_len_ff   <= 64'h0000000000000000;
      seg_cnt_ff   <= 64'h0000000000000000;
      pre_len_ff   <= 64'h0000000000000000;
      mask_ff      <= 32'h00000000;
      buf_bytes_ff <= 32'h00000000;
      interlace_ff <= 1'b0;
    end
    else if (wr_pend_ff)
    begin
      case (wr_addr_ff)
        `ADR_OPERATING_MODE_SELECT: mode_ff <= hwdata;                       // [RULE1]
        `ADR_SEGMENT_LENGTH_LO:     seg_len_ff[31:0] <= hwdata;              // [RULE5]
        `ADR_SEGMENT_LENGTH_HI:     seg_len_ff[63:32] <= hwdata;
        `ADR_SEGMENT_COUNT_LO:      seg_cnt_ff[31:0] <= hwdata;              // [RULE6]
        `ADR_SEGMENT_COUNT_HI:      seg_cnt_ff[63:32] <= hwdata;
        `ADR_PRE_TRIGGER_LO:        pre_len_ff[31:0] <= hwdata;              // [RULE4]
        `ADR_PRE_TRIGGER_HI:        pre_len_ff[63:32] <= hwdata;
        `ADR_IRQ_MASK:              mask_ff <= hwdata & `ST_USED_MASK;
        `ADR_HOST_BUFFER_BYTES:     buf_bytes_ff <= hwdata;                  // [RULE14]
        `ADR_RATE_CONTROL:          interlace_ff <= hwdata[0];               // [RULE12]
        default:                    mode_ff <= mode_ff;
      endcase
    end
  end

  // ==========================================
  // start checks, interlace has its own limits
  assign step_mask = interlace_ff ? 3'h7 : 3'h3;                             // [RULE13]
  assign pre_min   = interlace_ff ? `PRE_MIN_INTERLACE : `PRE_MIN_NORMAL;    // [RULE13]
  assign seg_min   = interlace_ff ? `SEG_MIN_INTERLACE : `SEG_MIN_NORMAL;    // [RULE13]
  assign params_ok = ((pre_len_ff[2:0] & step_mask) == 3'h0) &              // [RULE11]
                     ((seg_len_ff[2:0] & step_mask) == 3'h0) &
                     (pre_len_ff >= pre_min) & (seg_len_ff >= seg_min) &
                     (pre_len_ff <= PRE_DEPTH);                              // [RULE9]
  assign begin_ok  = wr_cmd & hwdata[`CMD_BEGIN_CAPTURE] & (state_ff == S_IDLE) &
                     (mode_ff == `MODE_CONTINUOUS_STREAM);                   // [RULE1]
  assign perr_evt  = begin_ok & ~params_ok;

  // ==========================================
  // sample selection, interlace alternates the two converters
  assign sample  = (interlace_ff & phase_ff) ? adc1_data : adc0_data;       // [RULE12]
  assign capture = (state_ff == S_PREFILL) | (state_ff == S_ARMED) | (state_ff == S_RUN);
  assign take    = capture & sample_en;

  // converter phase toggle
  always @(posedge mclk)
  begin
    if (srst | ~capture)
      phase_ff <= 1'b0;
    else if (take & interlace_ff)
      phase_ff <= ~phase_ff;
  end

  // ==========================================
  // pre-trigger fifo acts as a delay line ahead of the main memory
  assign pre_cnt64   = {{(64-PRE_AW-1){1'b0}}, pre_count};
  assign pre_reached = (pre_cnt64 >= pre_len_ff);
  assign last_sample = (in_seg_ff == seg_len_ff - 64'h1) &
                       (seg_cnt_ff != 64'h0) & (loops_done_ff == seg_cnt_ff - 64'h1);
  assign pre_push    = take & ~pre_full;                                     // [RULE9]
  // once the window is full every new sample drops the oldest, unless pre_length equals PRE_DEPTH and the new sample is dropped, so exactly pre_length are kept
  assign pre_pop     = (((state_ff == S_PREFILL) | (state_ff == S_ARMED)) & pre_push & pre_reached) | // [RULE4] [RULE17]
                       mem_push;
  assign mem_push    = ((state_ff == S_RUN) | (state_ff == S_FLUSH)) &
                       ~pre_empty & ~mem_full & ~finished;                   // [RULE4]
  assign ovr_evt     = take & pre_full & (state_ff == S_RUN);                // [RULE16]
  assign finished    = (state_ff == S_FLUSH);

  byte_fifo #(.WIDTH(8), .DEPTH(PRE_DEPTH), .AW(PRE_AW)) u_pre_fifo (
    .mclk  (mclk),
    .srst  (srst),
    .flush (begin_ok),
    .push  (pre_push),
    .wdata (sample),
    .pop   (pre_pop),
    .rdata (pre_rdata),
    .count (pre_count),
    .full  (pre_full),
    .empty (pre_empty)
  );

  // whole on-board memory as fifo, one byte per sample
  byte_fifo #(.WIDTH(8), .DEPTH(MEM_BYTES), .AW(MEM_AW)) u_mem_fifo (        // [RULE3] [RULE10]
    .mclk  (mclk),
    .srst  (srst),
    .flush (begin_ok),
    .push  (mem_push),
    .wdata (pre_rdata),
    .pop   (mem_pop),
    .rdata (mem_rdata),
    .count (mem_count),
    .full  (mem_full),
    .empty (mem_empty)
  );

  // ==========================================
  // acquisition sequencer
  always @(posedge mclk)
  begin
    if (srst)
    begin
      state_ff      <= S_IDLE;
      arm_ff        <= 1'b0;
      in_seg_ff     <= 64'h0;
      loops_done_ff <= 64'h0;
    end
    else
    begin
      if (wr_cmd & hwdata[`CMD_ARM_TRIGGER])
        arm_ff <= 1'b1;
      case (state_ff)
        S_IDLE:
        begin
          in_seg_ff     <= 64'h0;
          loops_done_ff <= 64'h0;
          if (begin_ok & params_ok)
            state_ff <= S_PREFILL;
        end
        S_PREFILL:
          if (pre_reached)
            state_ff <= S_ARMED;                                             // [RULE17]
        S_ARMED:
          if (trig_in & arm_ff)
            state_ff <= S_RUN;                                               // [RULE17]
        S_RUN:
        begin
          if (mem_push)
          begin
            if (last_sample)
              state_ff <= S_FLUSH;                                           // [RULE7]
            if (in_seg_ff == seg_len_ff - 64'h1)
            begin
              in_seg_ff     <= 64'h0;
              loops_done_ff <= loops_done_ff + 64'h1;                        // [RULE6]
            end
            else
              in_seg_ff <= in_seg_ff + 64'h1;                                // [RULE5]
          end
        end
        S_FLUSH:
          if (mem_empty & ~out_valid)
            state_ff <= S_IDLE;                                              // [RULE18]
        default:
          state_ff <= S_IDLE;
      endcase
      if (wr_cmd & hwdata[`CMD_STOP])
      begin
        state_ff <= S_IDLE;                                                  // [RULE8]
        arm_ff   <= 1'b0;
      end
      if (state_ff == S_IDLE)
        arm_ff <= arm_ff & ~(begin_ok & params_ok) |
                  (wr_cmd & hwdata[`CMD_ARM_TRIGGER]);
    end
  end

  // ==========================================
  // host output stage, limited by free host buffer space
  assign mem_pop = ~mem_empty & (credit_ff != 32'h0) & (~out_valid | out_ready);

  always @(posedge mclk)
  begin
    if (srst)
    begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
    end
    else
    begin
      if (mem_pop)
      begin
        out_valid <= 1'b1;
        out_data  <= mem_rdata;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

  // free space credit: freed bytes add, every sent byte takes one
  always @(posedge mclk)
  begin
    if (srst)
      credit_ff <= 32'h0;
    else if (begin_ok)
      credit_ff <= buf_bytes_ff;                                             // [RULE14]
    else
      credit_ff <= credit_ff + (freed_wr ? hwdata : 32'h0) -
                   {31'h0, mem_pop};                                         // [RULE15]
  end

  // ==========================================
  // sticky status, cleared by reading, a new event wins
  assign done_evt = finished & mem_empty & ~out_valid;

  always @(posedge mclk)
  begin
    if (srst)
      status_ff <= 32'h0;
    else
    begin
      status_ff <= stat_rd ? 32'h0 : status_ff;
      if (perr_evt)
        status_ff[`ST_PARAM_ERROR] <= 1'b1;
      if (done_evt)
        status_ff[`ST_DONE] <= 1'b1;                                         // [RULE18]
      if (ovr_evt)
        status_ff[`ST_OVERRUN] <= 1'b1;                                      // [RULE16]
    end
  end

  assign irq = |(status_ff & mask_ff);
endmodule

// >>> verification/host_sink.sv
// host transfer engine model that takes the byte stream
`timescale 1ns/1ps
module host_sink (
  // clock and reset
  input  wire       mclk,
  input  wire       srst,
  // pacing
  input  wire       slow,
  // byte stream
  input  wire [7:0] out_data,
  input  wire       out_valid,
  output logic      out_ready
);
  logic [7:0] got[$];
  logic [2:0] cnt_ff;
  // takes a byte on each valid and ready edge, stalls half the time when slow
  always @(posedge mclk)
  begin
    if (srst)
    begin
      out_ready <= 1'b0;
      cnt_ff    <= 3'h0;
    end
    else
    begin
      if (out_valid && out_ready)
        got.push_back(out_data);
      cnt_ff    <= cnt_ff + 3'h1;
      out_ready <= !slow || cnt_ff[1];
    end
  end
endmodule

// >>> verification/stream_acq_properties.sv
// assertion checker for the streaming acquisition controller
`timescale 1ns/1ps
`include "stream_acq_defines.vh"
module stream_acq_checker (
  // clock and reset
  input wire        mclk,
  input wire        srst,
  // bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // trigger and stream
  input wire        trig_in,
  input wire [7:0]  out_data,
  input wire        out_valid,
  input wire        out_ready,
  input wire        irq
);
  logic        wr_ff, rd_ff, begun_ff, trig_ff;
  logic [15:0] wa_ff, ra_ff;
  logic [31:0] mode_ff, buf_ff, credit_ff;
  wire         take = hsel && hready && htrans[1];
  wire         beat = out_valid && out_ready;
  wire         go   = wr_ff && wa_ff == `ADR_COMMAND && hwdata[`CMD_BEGIN_CAPTURE];
  wire         free = wr_ff && wa_ff == `ADR_HOST_FREED_BYTES;
  // shadows of bus phases, mode, buffer size and transfer credit
  always @(posedge mclk)
  begin
    if (srst)
    begin
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      begun_ff  <= 1'b0;
      trig_ff   <= 1'b0;
      wa_ff     <= 16'h0;
      ra_ff     <= 16'h0;
      mode_ff   <= `MODE_MEMORY_SINGLE;
      buf_ff    <= 32'h0;
      credit_ff <= 32'h0;
    end
    else
    begin
      wr_ff     <= take && hwrite;
      rd_ff     <= take && !hwrite;
      wa_ff     <= haddr[15:0];
      ra_ff     <= haddr[15:0];
      begun_ff  <= begun_ff || go;
      trig_ff   <= !go && (trig_ff || (trig_in && begun_ff));
      if (wr_ff && wa_ff == `ADR_OPERATING_MODE_SELECT)
        mode_ff <= hwdata;
      if (wr_ff && wa_ff == `ADR_HOST_BUFFER_BYTES)
        buf_ff <= hwdata;
      credit_ff <= go ? buf_ff : credit_ff + (free ? hwdata : 32'h0) - {31'h0, beat};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  hready_const_a: assert property (hreadyout)
    else $error("hreadyout low");
  okay_resp_a: assert property (!hresp)
    else $error("hresp not okay");
  reset_quiet_a: assert property ($fell(srst) |-> !out_valid && !irq && hrdata == 32'h0)
    else $error("outputs busy after reset");
  mode_readback_a: assert property (rd_ff && ra_ff == `ADR_OPERATING_MODE_SELECT |-> hrdata == mode_ff)
    else $error("mode readback differs");
  zero_read_a: assert property (rd_ff && (ra_ff == `ADR_COMMAND || ra_ff == 16'h0020) |-> hrdata == 32'h0)
    else $error("write-only or unmapped read not zero");
  rdata_hold_a: assert property (!rd_ff |-> $stable(hrdata))
    else $error("hrdata moved without read");
  stream_mode_a: assert property (out_valid |-> mode_ff == `MODE_CONTINUOUS_STREAM)
    else $error("output outside stream mode");
  post_trigger_a: assert property (out_valid |-> trig_ff)
    else $error("output before trigger");
  credit_limit_a: assert property (beat |-> credit_ff != 32'h0)
    else $error("byte sent without host space");
  beat_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled byte changed");
  cover property (beat);
  cover property ($rose(irq));
  cover property (out_valid && !out_ready);
endmodule
bind fifo_stream_acquisition stream_acq_checker u_chk (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .trig_in(trig_in), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .irq(irq));

// >>> verification/fifo_stream_acquisition_tb.sv
// self-checking bench for the streaming acquisition controller
`timescale 1ns/1ps
`include "stream_acq_defines.vh"
module fifo_stream_acquisition_tb;
  logic        mclk, srst, hsel, hwrite, sample_en, trig_in, slow;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  adc0_data, adc1_data;
  wire         hready, hreadyout, hresp, out_valid, out_ready, irq;
  wire  [31:0] hrdata;
  wire  [7:0]  out_data;
  int          n_errors, num_checks, k;
  assign hready = hreadyout;
  // design with small memories
  fifo_stream_acquisition #(.MEM_BYTES(64), .MEM_AW(6), .PRE_DEPTH(32), .PRE_AW(5)) u_dut (.mclk(mclk),
    .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_en(sample_en),
    .adc0_data(adc0_data), .adc1_data(adc1_data), .trig_in(trig_in), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .irq(irq));
  host_sink u_sink (.mclk(mclk), .srst(srst), .slow(slow), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(posedge mclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        n_errors++;
        give_verdict;
      end
      @(posedge mclk);
    end
  endtask
  // one single word transfer, address phase then data phase
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {16'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task cr(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, e);
  endtask
  task state(input logic [2:0] e);
    logic [31:0] x;
    bus(1'b0, `ADR_LIVE_STATE, 32'h0, x);
    check({29'h0, x[30:28]}, {29'h0, e});
  endtask
  task feed(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      sample_en <= 1'b1;
      adc0_data <= k[7:0];
      adc1_data <= 8'h80 | k[7:0];
      k++;
    end
    @(posedge mclk);
    sample_en <= 1'b0;
  endtask
  task trig;
    @(posedge mclk);
    trig_in <= 1'b1;
    @(posedge mclk);
    trig_in <= 1'b0;
  endtask
  task setup(input logic il, input int pre, input int seg, input int cnt, input int bytes);
    wr(`ADR_RATE_CONTROL, {31'h0, il});
    wr(`ADR_PRE_TRIGGER_LO, pre);
    wr(`ADR_SEGMENT_LENGTH_LO, seg);
    wr(`ADR_SEGMENT_COUNT_LO, cnt);
    wr(`ADR_HOST_BUFFER_BYTES, bytes);
    k = 0;
    u_sink.got.delete();
  endtask
  function logic [31:0] expb(input int kk, input logic il);
    return (il && kk[0]) ? {24'h0, 8'h80 | kk[7:0]} : {24'h0, kk[7:0]};
  endfunction
  task t_regs;
    cr(`ADR_OPERATING_MODE_SELECT, `MODE_MEMORY_SINGLE);
    wr(`ADR_OPERATING_MODE_SELECT, `MODE_CONTINUOUS_STREAM);
    cr(`ADR_OPERATING_MODE_SELECT, `MODE_CONTINUOUS_STREAM);
    wr(`ADR_SEGMENT_LENGTH_HI, 32'h5);
    cr(`ADR_SEGMENT_LENGTH_HI, 32'h5);
    wr(`ADR_SEGMENT_LENGTH_HI, 32'h0);
    cr(16'h0020, 32'h0);
    cr(`ADR_COMMAND, 32'h0);
    $display("register test done");
  endtask
  task t_param;
    setup(1'b1, 4, 16, 1, 64);
    wr(`ADR_COMMAND, 32'h3);
    @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    wr(`ADR_IRQ_MASK, 32'h1);
    @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    cr(`ADR_IRQ_STATUS, 32'h1);
    @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    state(3'h0);
    setup(1'b0, 6, 8, 1, 64);
    wr(`ADR_COMMAND, 32'h3);
    cr(`ADR_IRQ_STATUS, 32'h1);
    wr(`ADR_IRQ_MASK, 32'h0);
    $display("parameter test done");
  endtask
  task t_finite(input logic il);
    int pre, tot, n;
    logic [31:0] x;
    pre = 4 << il;
    tot = 16 << il;
    setup(il, pre, 8 << il, 2, 64);
    slow <= 1'b1;
    wr(`ADR_IRQ_MASK, 32'h200);
    wr(`ADR_COMMAND, 32'h3);
    feed(pre - 1);
    state(3'h1);
    feed(6);
    state(3'h2);
    trig;
    feed(tot - pre + 4);
    n = 0;
    x = 32'h10000000;
    while (x[30:28] !== 3'h0)
    begin
      n++;
      if (n > 100)
      begin
        n_errors++;
        give_verdict;
      end
      bus(1'b0, `ADR_LIVE_STATE, 32'h0, x);
    end
    check({31'h0, irq}, 32'h1);
    cr(`ADR_IRQ_STATUS, 32'h200);
    check(u_sink.got.size(), tot);
    for (int i = 0; i < tot; i++)
      check({24'h0, u_sink.got[i]}, expb(5 + i, il));
    $display("finite capture test done, interlace %0d", il);
  endtask
  task t_stream;
    int n;
    setup(1'b0, 4, 8, 0, 8);
    slow <= 1'b0;
    wr(`ADR_IRQ_MASK, 32'h400);
    wr(`ADR_COMMAND, 32'h3);
    feed(10);
    trig;
    feed(120);
    check(u_sink.got.size(), 8);
    cr(`ADR_HOST_AVAILABLE_BYTES, 32'h8);
    check({31'h0, irq}, 32'h1);
    cr(`ADR_IRQ_STATUS, 32'h400);
    wr(`ADR_HOST_FREED_BYTES, 32'h8);
    n = 0;
    while (u_sink.got.size() < 16)
    begin
      n++;
      if (n > 100)
      begin
        n_errors++;
        give_verdict;
      end
      @(posedge mclk);
    end
    for (int i = 8; i < 16; i++)
      check({24'h0, u_sink.got[i]}, expb(6 + i, 1'b0));
    wr(`ADR_COMMAND, 32'h4);
    state(3'h0);
    cr(`ADR_IRQ_STATUS, 32'h0);
    $display("endless stream test done");
  endtask
  initial
  begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sample_en = 1'b0;
    adc0_data = 8'h0;
    adc1_data = 8'h0;
    trig_in = 1'b0;
    slow = 1'b0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    t_regs;
    t_param;
    t_finite(1'b0);
    t_finite(1'b1);
    t_stream;
    give_verdict;
  end
endmodule
